/* File: gscp_params.svh */
/*
 * Constants of the gyro serial conversion port: frame layout, control
 * word field positions, reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef GSCP_PARAMS_SVH
`define GSCP_PARAMS_SVH

// frame layout
`define GSCP_FRAME_EDGES       5'h10
`define GSCP_CTL_EDGES         5'h0C
`define GSCP_CNT_W             5
`define GSCP_CTL_W             12
`define GSCP_WORD_W            16
`define GSCP_RES_W             12
`define GSCP_BUF_W             14

// control word fields, msb first on the wire
`define GSCP_CTL_WRITE_BIT     11
`define GSCP_CTL_SEL1_BIT      7
`define GSCP_CTL_SEL0_BIT      6
`define GSCP_CTL_FMT_BIT       0

// reset values
`define GSCP_CHAN_RESET        2'h0
`define GSCP_FMT_RESET         1'b0

// timing
`define GSCP_SYS_CLK_NS        8
`define GSCP_READY_NS          1000
`define GSCP_WAKE_W            8

`endif

/* File: gscp_pkg.sv */
/*
 * Types of the gyro serial conversion port.
 * Assumes gscp_params.svh is on the include path.
 */
`include "gscp_params.svh"

package gscp_pkg;

    typedef enum logic [1:0] {
        GSCP_CH_RATE = 2'h0,
        GSCP_CH_TEMP = 2'h1,
        GSCP_CH_AUX1 = 2'h2,
        GSCP_CH_AUX2 = 2'h3
    } gscp_chan_t;

    typedef logic [`GSCP_CTL_W-1:0]  gscp_ctl_t;
    typedef logic [`GSCP_WORD_W-1:0] gscp_word_t;

endpackage

/* File: gscp_buf2.sv */
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module gscp_buf2 #(
    parameter int W = 14
) (
    input  wire logic         sys_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] in_data,
    input  wire logic         in_valid,
    output logic              in_ready,
    output logic [W-1:0]      out_data,
    output logic              out_valid,
    input  wire logic         out_ready
);

    logic [W-1:0] mem_reg [2];
    logic         wptr_reg;
    logic         rptr_reg;
    logic [1:0]   cnt_reg;
    logic         push;
    logic         pop;

    assign in_ready  = (cnt_reg != 2'h2);
    assign out_valid = (cnt_reg != 2'h0);
    assign out_data  = mem_reg[rptr_reg];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always_ff @(posedge sys_clk) begin
        if (push) begin
            mem_reg[wptr_reg] <= in_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wptr_reg <= 1'b0;
            rptr_reg <= 1'b0;
            cnt_reg  <= 2'h0;
        end else begin
            if (push) begin
                wptr_reg <= ~wptr_reg;
            end
            if (pop) begin
                rptr_reg <= ~rptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + 2'h1;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - 2'h1;
            end
        end
    end

endmodule

`default_nettype wire

/* File: gscp_port.sv */
/*
 * Serial conversion and control port: a host frames each transfer with
 * chip select, shifts a control word in and reads the previous result out
 * on the serial clock; the system side drives the converter and feeds
 * results back through a two-entry buffer.
 * Assumes the serial clock stands still outside frames and that result
 * words arrive on sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none

`include "gscp_params.svh"

// Behaviour
// - control bits on serial data in are taken at serial clock falling edges
// - result bits move onto serial data out at serial clock falling edges
// - the serial clock runs the converter; a conversion spans 16 clock periods (here a sys_clk pulse on conv_start starts it instead)
// - chip select low frames a transfer and starts a conversion
// - an auxiliary input reaches track-and-hold only when selected
// - serial data out drives from chip select low until the 16th falling edge, high impedance otherwise
// - ready within 1 us after leaving power-down; host waits that long
// - only the first twelve falling edges load the 12-bit control word
// - a frame's control word configures the following conversion
module gscp_port (
    input  wire logic                    sys_clk,
    input  wire logic                    srst,
    input  wire logic                    sclk,
    input  wire logic                    cs_n,
    input  wire logic                    din,
    output logic                         dout,
    output logic                         dout_oe,
    input  wire logic                    power_down,
    output logic                         dev_ready,
    output logic                         conv_start,
    output gscp_pkg::gscp_chan_t         conv_channel,
    output logic                         output_format_select,
    output logic                         aux_route_1,
    output logic                         aux_route_2,
    input  wire logic [`GSCP_RES_W-1:0]  res_data,
    input  wire logic [1:0]              res_chan,
    input  wire logic                    res_valid,
    output logic                         res_ready
);

    // count stops two edges short: ready is registered, so 1 us still holds
    localparam int READY_CYCLES = `GSCP_READY_NS / `GSCP_SYS_CLK_NS - 2;

    ////////////////////////////////////////////////////////////////////////
    // link domain, serial clock falling edges

    logic [`GSCP_CNT_W-1:0]  edge_cnt_reg;
    logic [`GSCP_CTL_W-1:0]  ctl_shift_reg;
    logic [`GSCP_WORD_W-1:0] tx_reg;
    logic [`GSCP_CTL_W-1:0]  ctl_word_reg;
    logic                    frame_full_reg;
    gscp_pkg::gscp_word_t    hold_reg;

    // chip select high clears the edge count, control shift and transmit registers
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            edge_cnt_reg <= '0;
        end else if (edge_cnt_reg != `GSCP_FRAME_EDGES) begin
            edge_cnt_reg <= edge_cnt_reg + 5'h01;
        end
    end

    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            ctl_shift_reg <= '0;
        end else if (edge_cnt_reg < `GSCP_CTL_EDGES) begin
            ctl_shift_reg <= {ctl_shift_reg[`GSCP_CTL_W-2:0], din};
        end
    end

    // leading bit is zero before the first edge; hold word is stable here
    always_ff @(negedge sclk or posedge cs_n) begin
        if (cs_n) begin
            tx_reg <= '0;
        end else if (edge_cnt_reg == 5'h00) begin
            tx_reg <= {hold_reg[`GSCP_WORD_W-2:0], 1'b0};
        end else begin
            tx_reg <= {tx_reg[`GSCP_WORD_W-2:0], 1'b0};
        end
    end

    assign dout    = tx_reg[`GSCP_WORD_W-1];
    assign dout_oe = !cs_n && (edge_cnt_reg != `GSCP_FRAME_EDGES);

    // completed control word, stable until the next frame's 16th edge
    always_ff @(negedge sclk or posedge srst) begin
        if (srst) begin
            frame_full_reg <= 1'b0;
            ctl_word_reg   <= '0;
        end else if (edge_cnt_reg == `GSCP_FRAME_EDGES - 5'h01) begin
            frame_full_reg <= 1'b1;
            ctl_word_reg   <= ctl_shift_reg;
        end else if (edge_cnt_reg == 5'h00) begin
            frame_full_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // crossings into the system domain

    logic cs_meta_reg;
    logic cs_sync_reg;
    logic cs_prev_reg;
    logic full_meta_reg;
    logic full_sync_reg;
    logic frame_begin;
    logic frame_end;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cs_meta_reg   <= 1'b1;
            cs_sync_reg   <= 1'b1;
            cs_prev_reg   <= 1'b1;
            full_meta_reg <= 1'b0;
            full_sync_reg <= 1'b0;
        end else begin
            cs_meta_reg   <= cs_n;
            cs_sync_reg   <= cs_meta_reg;
            cs_prev_reg   <= cs_sync_reg;
            full_meta_reg <= frame_full_reg;
            full_sync_reg <= full_meta_reg;
        end
    end

    assign frame_begin = cs_prev_reg && !cs_sync_reg;
    assign frame_end   = !cs_prev_reg && cs_sync_reg;

    ////////////////////////////////////////////////////////////////////////
    // configuration for the following conversion

    gscp_pkg::gscp_chan_t cfg_chan_reg;
    logic                 cfg_fmt_reg;
    logic                 cfg_load;

    assign cfg_load = frame_end && full_sync_reg && ctl_word_reg[`GSCP_CTL_WRITE_BIT];

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_chan_reg <= gscp_pkg::gscp_chan_t'(`GSCP_CHAN_RESET);
            cfg_fmt_reg  <= `GSCP_FMT_RESET;
        end else if (cfg_load) begin
            cfg_chan_reg <= gscp_pkg::gscp_chan_t'({ctl_word_reg[`GSCP_CTL_SEL1_BIT],
                                                     ctl_word_reg[`GSCP_CTL_SEL0_BIT]});
            cfg_fmt_reg  <= ctl_word_reg[`GSCP_CTL_FMT_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // converter control

    logic wake_done;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            conv_start           <= 1'b0;
            conv_channel         <= gscp_pkg::gscp_chan_t'(`GSCP_CHAN_RESET);
            output_format_select <= `GSCP_FMT_RESET;
            aux_route_1          <= 1'b0;
            aux_route_2          <= 1'b0;
        end else begin
            conv_start <= frame_begin && wake_done;
            if (frame_begin) begin
                conv_channel         <= cfg_chan_reg;
                output_format_select <= cfg_fmt_reg;
            end
            aux_route_1 <= (cfg_chan_reg == gscp_pkg::GSCP_CH_AUX1);
            aux_route_2 <= (cfg_chan_reg == gscp_pkg::GSCP_CH_AUX2);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // wake-up timer after reset or power-down

    logic [`GSCP_WAKE_W-1:0] wake_cnt_reg;

    assign wake_done = (wake_cnt_reg == READY_CYCLES[`GSCP_WAKE_W-1:0]);

    always_ff @(posedge sys_clk) begin
        if (srst || power_down) begin
            wake_cnt_reg <= '0;
            dev_ready    <= 1'b0;
        end else begin
            if (!wake_done) begin
                wake_cnt_reg <= wake_cnt_reg + 8'h01;
            end
            dev_ready <= wake_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // result path: buffer, then hold word loaded between frames

    logic [`GSCP_BUF_W-1:0] buf_data;
    logic                   buf_valid;
    logic                   buf_take;

    gscp_buf2 #(
        .W (`GSCP_BUF_W)
    ) u_buf (
        .sys_clk   (sys_clk),
        .srst      (srst),
        .in_data   ({res_chan, res_data}),
        .in_valid  (res_valid),
        .in_ready  (res_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (buf_take)
    );

    // only right after chip select rises, well inside the frame gap
    assign buf_take = frame_end;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            hold_reg <= '0;
        end else if (frame_end && buf_valid) begin
            hold_reg <= {2'h0, buf_data};
        end
    end

endmodule

`default_nettype wire

/* File: gscp_port_assertions.sv */
/* Checker of the serial conversion port's ready, start, channel and aux route outputs and its serial data out and enable.
   Assumes it is bound onto gscp_port; one clock, srst synchronous. */
`timescale 1ns/1ps
`default_nettype none
module gscp_port_chk (
    input wire logic                 sys_clk,
    input wire logic                 srst,
    input wire logic                 cs_n,
    input wire logic                 dout,
    input wire logic                 dout_oe,
    input wire logic                 power_down,
    input wire logic                 dev_ready,
    input wire logic                 conv_start,
    input wire gscp_pkg::gscp_chan_t conv_channel,
    input wire logic                 aux_route_1,
    input wire logic                 aux_route_2
);
    logic [7:0] wake_reg;
    // cycles since reset and power-down were both released
    always_ff @(posedge sys_clk) begin
        if (srst || power_down) wake_reg <= 8'h00;
        else if (wake_reg != 8'hFF) wake_reg <= wake_reg + 8'h01;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    property p_ready_bound; wake_reg >= 8'h7D |-> dev_ready; endproperty
    a_ready_bound: assert property (p_ready_bound) else $error("ready late");
    property p_sleep; power_down [*2] |-> !dev_ready; endproperty
    a_sleep: assert property (p_sleep) else $error("ready in power-down");
    property p_start_ready; conv_start |-> dev_ready; endproperty
    a_start_ready: assert property (p_start_ready) else $error("start while not ready");
    property p_start_pulse; conv_start |=> !conv_start; endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse too long");
    property p_start_lat; $fell(cs_n) && dev_ready |-> ##[1:5] conv_start; endproperty
    a_start_lat: assert property (p_start_lat) else $error("no start after select");
    property p_oe_idle; cs_n |-> !dout_oe; endproperty
    a_oe_idle: assert property (p_oe_idle) else $error("dout driven unselected");
    property p_oe_open; $fell(cs_n) |-> dout_oe && !dout; endproperty
    a_oe_open: assert property (p_oe_open) else $error("dout not opened low");
    property p_route;
        conv_start |-> aux_route_1 == (conv_channel == gscp_pkg::GSCP_CH_AUX1)
                    && aux_route_2 == (conv_channel == gscp_pkg::GSCP_CH_AUX2);
    endproperty
    a_route: assert property (p_route) else $error("aux route mismatch");
    property p_chan_hold; !$stable(conv_channel) && dev_ready |-> conv_start; endproperty
    a_chan_hold: assert property (p_chan_hold) else $error("channel moved mid-frame");
endmodule
bind gscp_port gscp_port_chk gscp_port_chk_i (.sys_clk(sys_clk), .srst(srst), .cs_n(cs_n),
    .dout(dout), .dout_oe(dout_oe), .power_down(power_down), .dev_ready(dev_ready),
    .conv_start(conv_start), .conv_channel(conv_channel), .aux_route_1(aux_route_1),
    .aux_route_2(aux_route_2));
`default_nettype wire

/* File: gscp_host_model.sv */
/* Host side of the serial link: frames, clock and control bits.
   Assumes the testbench calls frame() and waits for its return. */
`timescale 1ns/1ps
`default_nettype none
module gscp_host_model (
    output logic      sclk,
    output logic      cs_n,
    output logic      din,
    input  wire logic dout,
    input  wire logic dout_oe
);
    logic oe_tail;
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end
    // 16 clocks at 15 ns, msb first; clock idles high between frames
    task automatic frame(input gscp_pkg::gscp_word_t tx, output gscp_pkg::gscp_word_t rx);
        cs_n = 1'b0;
        #20;
        for (int k = 15; k >= 0; k--) begin
            din = tx[k];
            #7.5;
            rx[k] = dout_oe ? dout : ~dout;
            sclk = 1'b0;
            #7.5;
            sclk = 1'b1;
        end
        oe_tail = dout_oe;
        #20;
        cs_n = 1'b1;
        din = ~din;
        #50;
    endtask
endmodule
`default_nettype wire

/* File: gscp_port_tb.sv */
/* Self-checking testbench of the serial conversion port.
   Assumes gscp_host_model drives the link and the checker is bound. */
`timescale 1ns/1ps
`default_nettype none
`include "gscp_params.svh"
module gscp_port_tb;
    logic                     sys_clk, srst, sclk, cs_n, din, dout, dout_oe;
    logic                     power_down, dev_ready, conv_start, fmt_sel, aux1, aux2;
    logic                     res_valid, res_ready;
    logic [`GSCP_RES_W-1:0]   res_data;
    logic [1:0]               res_chan;
    gscp_pkg::gscp_chan_t     conv_channel;
    gscp_pkg::gscp_word_t     rx;
    int                       bad_count, checks;
    gscp_port gscp_port_i (.sys_clk(sys_clk), .srst(srst), .sclk(sclk), .cs_n(cs_n),
        .din(din), .dout(dout), .dout_oe(dout_oe), .power_down(power_down),
        .dev_ready(dev_ready), .conv_start(conv_start), .conv_channel(conv_channel),
        .output_format_select(fmt_sel), .aux_route_1(aux1), .aux_route_2(aux2),
        .res_data(res_data), .res_chan(res_chan), .res_valid(res_valid),
        .res_ready(res_ready));
    gscp_host_model gscp_host_model_i (.sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
        .dout_oe(dout_oe));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task push(input logic [13:0] w);
        logic ok;
        ok = 1'b0;
        @(posedge sys_clk);
        {res_chan, res_data} <= w;
        res_valid <= 1'b1;
        for (int i = 0; i < 50 && ok !== 1'b1; i++) begin
            @(negedge sys_clk);
            ok = res_ready;
            @(posedge sys_clk);
        end
        res_valid <= 1'b0;
    endtask
    task xfer(input logic w, input logic [1:0] ch, input logic f, input logic [3:0] tail);
        gscp_host_model_i.frame({w, 3'h0, ch, 4'hC, 1'b0, f, tail}, rx);
        chk("oe_tail", 16'h0, {15'h0, gscp_host_model_i.oe_tail});
        repeat (8) @(negedge sys_clk);
    endtask
    task wait_ready(input string nm);
        int n;
        n = 0;
        while (dev_ready !== 1'b1 && n < 300) begin
            @(negedge sys_clk);
            n++;
        end
        chk(nm, 16'h1, 16'(n <= `GSCP_READY_NS / `GSCP_SYS_CLK_NS));
    endtask
    task t_sleep;
        @(posedge sys_clk);
        power_down <= 1'b1;
        repeat (3) @(negedge sys_clk);
        chk("sleep", 16'h0, {15'h0, dev_ready});
        @(posedge sys_clk);
        power_down <= 1'b0;
        wait_ready("wake_again");
    endtask
    // results flow through the buffer; every channel code written once
    task t_chan;
        logic [15:0] exp [3];
        int p;
        exp = '{16'h0000, 16'h2ABC, 16'h1123};
        push(14'h2ABC);
        push(14'h1123);
        @(negedge sys_clk);
        chk("res_ready_full", 16'h0, {15'h0, res_ready});
        for (int c = 0; c < 4; c++) begin
            p = (c == 0) ? 0 : c - 1;
            xfer(1'b1, c[1:0], c[0], {4{~c[0]}});
            if (c < 3) chk("dout_word", exp[c], rx);
            chk("aux", {14'h0, c == 3, c == 2}, {14'h0, aux2, aux1});
            chk("chan", {14'h0, p[1:0]}, {14'h0, conv_channel});
            chk("fmt", {15'h0, p[0]}, {15'h0, fmt_sel});
        end
    endtask
    // write flag low keeps config; trailing edges never reach the format bit
    task t_refuse;
        xfer(1'b0, 2'h1, 1'b0, 4'hF);
        chk("kept_aux", 16'h2, {14'h0, aux2, aux1});
        xfer(1'b1, 2'h1, 1'b0, 4'hF);
        chk("kept_chan", 16'h3, {14'h0, conv_channel});
        xfer(1'b1, 2'h0, 1'b1, 4'h0);
        chk("new_chan", 16'h1, {14'h0, conv_channel});
        chk("tail_fmt", 16'h0, {15'h0, fmt_sel});
    endtask
    initial begin
        srst = 1'b1;
        power_down = 1'b0;
        res_valid = 1'b0;
        res_data = '0;
        res_chan = 2'h0;
        bad_count = 0;
        checks = 0;
        repeat (16) @(posedge sys_clk);
        srst <= 1'b0;
        wait_ready("wake");
        t_sleep;
        t_chan;
        t_refuse;
        give_verdict;
    end
    initial begin
        #50000;
        bad_count++;
        $display("FAIL watchdog expected done seen hang");
        give_verdict;
    end
endmodule
`default_nettype wire
